// *** pkg/rxsi_cfg.svh ***
// Purpose: constants of the receive system interface control block
// Assumes: register index times four is the APB byte address
// Notes: indices follow the printed register offsets
`ifndef RXSI_CFG_SVH
`define RXSI_CFG_SVH

// ----------------------------------------
// register indices and address width
// ----------------------------------------
`define RXSI_IDX_CTRL1 8'h38
`define RXSI_IDX_CTRL2 8'h3a
`define RXSI_IDX_STAT 8'h3c
`define RXSI_IDX_MASK 8'h3e
`define RXSI_ADDR_W 10

// ----------------------------------------
// field positions
// ----------------------------------------
`define RXSI_C1_GAP_LSB 8
`define RXSI_C1_CAD_LSB 4
`define RXSI_C1_PARP 3
`define RXSI_C1_INV 2
`define RXSI_C1_REORD 1
`define RXSI_C1_HEC 0
`define RXSI_C2_MBL_LSB 8
`define RXSI_C2_LBL_LSB 0
`define RXSI_ST_CLK 0

// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define RXSI_C1_WMASK 16'h077f
`define RXSI_C2_WMASK 16'h3fff
`define RXSI_ST_WMASK 16'h0001
`define RXSI_C1_RST 16'h0000
`define RXSI_C2_RST 16'h0000
`define RXSI_MASK_RST 16'h0000

`endif

// *** pkg/rxsi_pkg.sv ***
// Purpose: types of the receive system interface control block
// Assumes: nothing
// Notes: bus mode and width come from the per-port common control
package rxsi_pkg;

  typedef enum logic [1:0] {
    RXSI_UTOPIA2 = 2'b00,
    RXSI_UTOPIA3 = 2'b01,
    RXSI_PKT2 = 2'b10,
    RXSI_SPI3 = 2'b11
  } rxsi_mode_e;

  typedef enum logic [1:0] {
    RXSI_W8 = 2'b00,
    RXSI_W16 = 2'b01,
    RXSI_W32 = 2'b10
  } rxsi_width_e;

  typedef enum logic [1:0] {
    RXSI_IDLE = 2'b00,
    RXSI_SEND = 2'b01,
    RXSI_GAP = 2'b11
  } rxsi_state_e;

  typedef struct packed {
    logic [31:0] data;
    logic sop;
    logic eop;
    logic hec;
    logic more;
  } rxsi_word_s;

  typedef struct packed {
    logic [31:0] data;
    logic parity;
    logic valid;
    logic sox;
    logic eop;
  } rxsi_bus_s;

endpackage : rxsi_pkg

// *** rtl/rxsi_top.sv ***
// Purpose: receive system interface control, status and output stage
// Assumes: source words come from pclk logic; rx_system_clock is foreign
// Notes: the link side moves one word per sampled rising link edge
`timescale 1ns/100ps
`default_nettype none
`include "rxsi_cfg.svh"

// What this block does
// - valid held low for programmed gap
// - zero gap keeps valid between packets
// - gap ignored in utopia and level 2
// - programmed transfers follow fifo empty indication
// - utopia2 flag drops after last payload
// - utopia3 flag drops on start edge
// - deassert timing ignored in packet modes
// - parity polarity selects odd or even
// - inversion bit flips availability flag polarity
// - reorder moves first byte to low lane
// - hec byte sent only when enabled
// - spi3 burst limit scales with width
// - continue past limit when no other
// - zero disables limit, one acts two at 32-bit width
// - loopback limits port to one xth
// - loopback limit floors per bus width
// - link clock toggling sets latched bit
module rxsi_top
  import rxsi_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RXSI_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // mode from common port control
  input wire rxsi_mode_e bus_mode,
  input wire rxsi_width_e bus_width,
  input wire logic loopback_en,
  // word source from the receive fifo
  input wire rxsi_word_s src_word,
  input wire logic src_valid,
  input wire logic src_empty,
  input wire logic cell_avail,
  input wire logic poll_avail,
  input wire logic other_port_ready,
  output logic src_take,
  output logic port_switch,
  // link side
  input wire logic rx_system_clock,
  output rxsi_bus_s rx_bus,
  output logic rx_direct_avail_flag,
  output logic rx_polled_avail_flag
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [8:0] burst_limit(input logic [5:0] mbl, input rxsi_width_e w);
    logic [8:0] n;
    n = {3'h0, mbl} + 9'h001;
    if (w == RXSI_W32 && mbl == 6'h01) n = 9'h003;
    case (w)
      RXSI_W32: burst_limit = n;
      RXSI_W16: burst_limit = {n[7:0], 1'b0};
      default: burst_limit = {n[6:0], 2'b00};
    endcase
  endfunction : burst_limit

  function automatic logic [7:0] lb_limit(input logic [7:0] x, input rxsi_width_e w);
    if (w == RXSI_W32 && x < 8'h02) lb_limit = 8'h02;
    else if (x == 8'h00) lb_limit = 8'h01;
    else lb_limit = x;
  endfunction : lb_limit

  function automatic logic [31:0] order_word(input logic [31:0] d, input logic re, input rxsi_width_e w);
    if (!re || w == RXSI_W8) order_word = d;
    else if (w == RXSI_W16) order_word = {16'h0000, d[7:0], d[15:8]};
    else order_word = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : order_word

  // ----------------------------------------
  // registers and apb decode
  // ----------------------------------------
  logic [15:0] ctrl1_ff, ctrl2_ff, stat_ff, mask_ff;
  logic [15:0] nxt_stat;
  wire logic [7:0] idx = paddr[`RXSI_ADDR_W-1:2];
  wire logic acc = psel && penable;
  wire logic hit_c1 = idx == `RXSI_IDX_CTRL1;
  wire logic hit_c2 = idx == `RXSI_IDX_CTRL2;
  wire logic hit_st = idx == `RXSI_IDX_STAT;
  wire logic hit_mk = idx == `RXSI_IDX_MASK;
  wire logic hit = (hit_c1 || hit_c2 || hit_st || hit_mk) && paddr[1:0] == 2'b00;
  wire logic wr = acc && pwrite && hit;

  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata = !hit ? 32'h0000_0000 :
                  hit_c1 ? {16'h0000, ctrl1_ff} :
                  hit_c2 ? {16'h0000, ctrl2_ff} :
                  hit_st ? {16'h0000, stat_ff} : {16'h0000, mask_ff};
  assign irq = |(stat_ff & mask_ff);

  wire logic [2:0] cfg_gap = ctrl1_ff[`RXSI_C1_GAP_LSB +: 3];
  wire logic [2:0] cfg_cad = ctrl1_ff[`RXSI_C1_CAD_LSB +: 3];
  wire logic cfg_parp = ctrl1_ff[`RXSI_C1_PARP];
  wire logic cfg_inv = ctrl1_ff[`RXSI_C1_INV];
  wire logic cfg_reord = ctrl1_ff[`RXSI_C1_REORD];
  wire logic cfg_hec = ctrl1_ff[`RXSI_C1_HEC];
  wire logic [5:0] cfg_mbl = ctrl2_ff[`RXSI_C2_MBL_LSB +: 6];
  wire logic [7:0] cfg_lbl = ctrl2_ff[`RXSI_C2_LBL_LSB +: 8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_ff <= `RXSI_C1_RST;
      ctrl2_ff <= `RXSI_C2_RST;
      mask_ff <= `RXSI_MASK_RST;
      stat_ff <= 16'h0000;
    end else begin
      if (wr && hit_c1) ctrl1_ff <= pwdata[15:0] & `RXSI_C1_WMASK;
      if (wr && hit_c2) ctrl2_ff <= pwdata[15:0] & `RXSI_C2_WMASK;
      if (wr && hit_mk) mask_ff <= pwdata[15:0] & `RXSI_ST_WMASK;
      stat_ff <= nxt_stat;
    end
  end

  // ----------------------------------------
  // link clock sampling
  // ----------------------------------------
  logic lclk_s1_ff, lclk_s2_ff, lclk_s3_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_s1_ff <= 1'b0;
      lclk_s2_ff <= 1'b0;
      lclk_s3_ff <= 1'b0;
    end else begin
      lclk_s1_ff <= rx_system_clock;
      lclk_s2_ff <= lclk_s1_ff;
      lclk_s3_ff <= lclk_s2_ff;
    end
  end
  wire logic lk = lclk_s2_ff && !lclk_s3_ff;

  // set wins over the write-one clear
  wire logic [15:0] st_clr = (wr && hit_st) ? (pwdata[15:0] & `RXSI_ST_WMASK) : 16'h0000;
  wire logic [15:0] st_set = {15'h0000, lk};
  assign nxt_stat = (stat_ff & ~st_clr) | st_set;

  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  rxsi_state_e st_ff, nxt_st;
  logic [2:0] gap_cnt_ff, nxt_gap_cnt;
  logic [8:0] burst_cnt_ff, nxt_burst_cnt;
  logic [7:0] thr_cnt_ff, nxt_thr_cnt;
  rxsi_bus_s bus_ff, nxt_bus;
  logic sw_ff;

  wire logic spi3 = bus_mode == RXSI_SPI3;
  wire logic pkt = bus_mode == RXSI_PKT2 || spi3;
  wire logic gap_used = spi3 && cfg_gap != 3'h0;
  wire logic [8:0] blim = burst_limit(cfg_mbl, bus_width);
  wire logic blim_en = spi3 && cfg_mbl != 6'h00;
  wire logic thr_ok = !loopback_en || thr_cnt_ff == 8'h00;
  wire logic send_st = st_ff == RXSI_SEND;
  wire logic resume = src_valid && (src_word.more || src_word.eop);
  assign src_take = lk && send_st && src_valid && thr_ok;
  wire logic drop = src_word.hec && !cfg_hec;
  wire logic out_w = src_take && !drop;
  wire logic bhit = blim_en && out_w && (burst_cnt_ff + 9'h001) >= blim;
  wire logic bswitch = bhit && other_port_ready;
  wire logic bstall = bhit && !other_port_ready && !src_word.more && !src_word.eop;
  wire logic go_gap = out_w && gap_used && (src_word.eop || bswitch);
  wire logic [31:0] odata = order_word(src_word.data, cfg_reord, bus_width);

  always_comb begin
    nxt_st = st_ff;
    nxt_gap_cnt = gap_cnt_ff;
    nxt_burst_cnt = burst_cnt_ff;
    nxt_thr_cnt = thr_cnt_ff;
    nxt_bus = bus_ff;
    if (lk) begin
      nxt_bus.valid = 1'b0;
      nxt_bus.sox = 1'b0;
      nxt_bus.eop = 1'b0;
      if (thr_cnt_ff != 8'h00) nxt_thr_cnt = thr_cnt_ff - 8'h01;
      case (st_ff)
        RXSI_IDLE: begin
          if (resume) nxt_st = RXSI_SEND;
        end
        RXSI_SEND: begin
          if (out_w) begin
            nxt_bus.data = odata;
            nxt_bus.parity = ^odata ^ ~cfg_parp;
            nxt_bus.valid = 1'b1;
            nxt_bus.sox = src_word.sop;
            nxt_bus.eop = src_word.eop;
            // count only while a limit applies, so a later limit starts from an empty burst
            nxt_burst_cnt = (src_word.eop || bhit || !blim_en) ? 9'h000 : burst_cnt_ff + 9'h001;
          end
          if (src_take && loopback_en) nxt_thr_cnt = lb_limit(cfg_lbl, bus_width) - 8'h01;
          if (go_gap) begin
            nxt_st = RXSI_GAP;
            nxt_gap_cnt = cfg_gap;
          end else if (bstall) begin
            nxt_st = RXSI_IDLE;
          end
        end
        RXSI_GAP: begin
          // valid stays low; the link layer may drop its enable here
          nxt_gap_cnt = gap_cnt_ff - 3'h1;
          if (gap_cnt_ff == 3'h1) nxt_st = RXSI_SEND;
        end
        default: nxt_st = RXSI_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= RXSI_IDLE;
      gap_cnt_ff <= 3'h0;
      burst_cnt_ff <= 9'h000;
      thr_cnt_ff <= 8'h00;
      bus_ff <= '0;
      sw_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      gap_cnt_ff <= nxt_gap_cnt;
      burst_cnt_ff <= nxt_burst_cnt;
      thr_cnt_ff <= nxt_thr_cnt;
      bus_ff <= nxt_bus;
      sw_ff <= lk && bswitch;
    end
  end
  assign rx_bus = bus_ff;
  assign port_switch = sw_ff;

  // ----------------------------------------
  // cell available timing
  // ----------------------------------------
  logic block_ff, nxt_block, pend_ff, nxt_pend;
  logic [2:0] cad_cnt_ff, nxt_cad_cnt;
  logic cad_run_ff, nxt_cad_run;
  logic dflag_ff, pflag_ff;

  always_comb begin
    nxt_block = block_ff;
    nxt_pend = pend_ff;
    nxt_cad_cnt = cad_cnt_ff;
    nxt_cad_run = cad_run_ff;
    if (lk) begin
      nxt_pend = 1'b0;
      if (pkt) begin
        nxt_block = 1'b0;
        nxt_cad_run = 1'b0;
      end else if (!cell_avail) begin
        nxt_block = 1'b0;
        nxt_cad_run = 1'b0;
      end else if (cfg_cad != 3'h0) begin
        if (!cad_run_ff && src_empty) begin
          nxt_cad_run = 1'b1;
          nxt_cad_cnt = cfg_cad;
        end else if (cad_run_ff && out_w) begin
          nxt_cad_cnt = cad_cnt_ff - 3'h1;
          if (cad_cnt_ff == 3'h1) begin
            nxt_block = 1'b1;
            nxt_cad_run = 1'b0;
          end
        end
      end else if (bus_mode == RXSI_UTOPIA3) begin
        if (out_w && src_word.sop) nxt_block = 1'b1;
      end else begin
        if (pend_ff) nxt_block = 1'b1;
        nxt_pend = out_w && src_word.eop;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_ff <= 1'b0;
      pend_ff <= 1'b0;
      cad_cnt_ff <= 3'h0;
      cad_run_ff <= 1'b0;
      dflag_ff <= 1'b0;
      pflag_ff <= 1'b0;
    end else begin
      block_ff <= nxt_block;
      pend_ff <= nxt_pend;
      cad_cnt_ff <= nxt_cad_cnt;
      cad_run_ff <= nxt_cad_run;
      dflag_ff <= (cell_avail && !nxt_block) ^ cfg_inv;
      pflag_ff <= poll_avail ^ cfg_inv;
    end
  end
  assign rx_direct_avail_flag = dflag_ff;
  assign rx_polled_avail_flag = pflag_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enter_gap;
    lk && send_st && go_gap;
  endsequence
  // the engine is in the gap state the cycle after the word that opens the gap
  sequence s_gap_hold;
    (st_ff == RXSI_GAP);
  endsequence

  a_gap_load: assert property (s_enter_gap |=> s_gap_hold and gap_cnt_ff == $past(cfg_gap))
    else $error("gap not loaded with programmed count");
  a_gap_quiet: assert property (lk && st_ff == RXSI_GAP |=> !rx_bus.valid)
    else $error("valid asserted during gap");
  a_gap_mode: assert property (!spi3 |-> st_ff != RXSI_GAP)
    else $error("gap used outside spi3 mode");
  a_parity_sense: assert property (lk && out_w |=> (^{rx_bus.data, rx_bus.parity}) == !$past(cfg_parp))
    else $error("parity sense wrong");
  a_hec_drop: assert property (src_take && drop |=> !rx_bus.valid)
    else $error("hec byte passed while disabled");
  a_reorder_lane: assert property (out_w && cfg_reord && bus_width == RXSI_W32
    |=> rx_bus.data[7:0] == $past(src_word.data[31:24]))
    else $error("first byte not on low lane");
  a_burst_bound: assert property (blim_en |-> burst_cnt_ff < blim)
    else $error("burst count passed its limit");
  a_u3_drop: assert property (lk && !pkt && cell_avail && cfg_cad == 3'h0 && bus_mode == RXSI_UTOPIA3
    && out_w && src_word.sop |=> block_ff ##1 rx_direct_avail_flag == cfg_inv)
    else $error("direct flag not dropped at start");
  a_pkt_noblock: assert property (pkt && lk |=> !block_ff)
    else $error("deassert timing applied in packet mode");
  a_clk_latch: assert property (lk |=> stat_ff[`RXSI_ST_CLK] [*2])
    else $error("clock activity not latched");
  a_irq_level: assert property (irq == |(stat_ff & mask_ff))
    else $error("interrupt not tied to status and mask");

endmodule : rxsi_top
`default_nettype wire

// *** verification/rxsi_link_model.sv ***
// Purpose: link-layer model on the receive system bus
// Assumes: rx_bus is settled at each rising link edge
// Notes: the link clock stands at 0 while run is low
`timescale 1ns/100ps
`default_nettype none
module rxsi_link_model
  import rxsi_pkg::*;
(
  // control
  input wire logic run,
  // link
  output logic rx_system_clock,
  input wire rxsi_bus_s rx_bus,
  // observation
  output logic [7:0] last_gap
);
  logic [7:0] idle_ff;
  initial begin
    rx_system_clock = 1'b0;
    last_gap = 8'h00;
    idle_ff = 8'h00;
    #7;
    forever begin
      #160;
      rx_system_clock = run ? ~rx_system_clock : 1'b0;
    end
  end
  // idle link edges before each word, where the link layer may pause
  always @(posedge rx_system_clock) begin
    if (rx_bus.valid) begin
      last_gap <= idle_ff;
      idle_ff <= 8'h00;
    end else begin
      idle_ff <= idle_ff + 8'h01;
    end
  end
endmodule : rxsi_link_model
`default_nettype wire

// *** verification/rxsi_top_tb.sv ***
// Purpose: self-checking bench of the receive system interface block
// Assumes: zero wait-state apb slave
// Notes: words are handed over one per detected link edge
`timescale 1ns/100ps
`default_nettype none
`include "rxsi_cfg.svh"
module rxsi_top_tb;
  import rxsi_pkg::*;
  localparam logic [9:0] A_C1 = 10'(`RXSI_IDX_CTRL1 * 4);
  localparam logic [9:0] A_C2 = 10'(`RXSI_IDX_CTRL2 * 4);
  localparam logic [9:0] A_ST = 10'(`RXSI_IDX_STAT * 4);
  localparam logic [9:0] A_MK = 10'(`RXSI_IDX_MASK * 4);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, loopback_en;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, q;
  rxsi_mode_e bus_mode;
  rxsi_width_e bus_width;
  rxsi_word_s src_word;
  logic src_valid, src_empty, cell_avail, poll_avail, other_port_ready, src_take, port_switch;
  logic rx_system_clock, rx_direct_avail_flag, rx_polled_avail_flag, run, e;
  rxsi_bus_s rx_bus, got;
  logic [7:0] last_gap;
  int n_errors, cmp_count, cycles;
  rxsi_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .bus_mode, .bus_width, .loopback_en, .src_word, .src_valid, .src_empty,
    .cell_avail, .poll_avail, .other_port_ready, .src_take, .port_switch, .rx_system_clock,
    .rx_bus, .rx_direct_avail_flag, .rx_polled_avail_flag);
  rxsi_link_model link (.run, .rx_system_clock, .rx_bus, .last_gap);
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [9:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd
  task automatic send(input logic [31:0] d, input logic s, input logic eo, input logic h);
    int n;
    n = 0;
    @(posedge pclk);
    src_word <= '{data: d, sop: s, eop: eo, hec: h, more: 1'b1};
    src_valid <= 1'b1;
    @(negedge pclk);
    while (src_take !== 1'b1 && n < 200) begin
      n++;
      @(negedge pclk);
    end
    chk(32'(n < 200), 32'h1);
    @(posedge pclk);
    src_valid <= 1'b0;
    @(negedge pclk);
    got = rx_bus;
  endtask : send
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(A_C1, 32'h0);
    rd(A_C2, 32'h0);
    rd(A_ST, 32'h0);
    rd(A_MK, 32'h0);
    apb(1'b1, A_C1, 32'hffffffff);
    rd(A_C1, 32'h077f);
    apb(1'b1, A_C2, 32'hffffffff);
    rd(A_C2, 32'h3fff);
    apb(1'b0, 10'h0fc, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b0, 10'h0e2, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, A_C1, 32'h0);
    apb(1'b1, A_C2, 32'h0);
  endtask : t_regs
  task automatic t_clk;
    apb(1'b1, A_MK, 32'h1);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    run <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(A_ST, 32'h1);
    chk(32'(irq), 32'h1);
    run <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b1, A_ST, 32'h1);
    repeat (40) @(posedge pclk);
    rd(A_ST, 32'h0);
    chk(32'(irq), 32'h0);
    run <= 1'b1;
    apb(1'b1, A_MK, 32'h0);
  endtask : t_clk
  task automatic t_flags;
    bus_mode <= RXSI_SPI3;
    cell_avail <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, A_C1, 32'(i) << 2);
      repeat (4) @(negedge pclk);
      chk(32'(rx_direct_avail_flag), 32'(i == 0));
      chk(32'(rx_polled_avail_flag), 32'(i != 0));
    end
  endtask : t_flags
  task automatic t_data;
    logic [31:0] x;
    bus_width <= RXSI_W32;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_C1, {28'h0, i[0], 1'b0, i[1], 1'b0});
      send(32'h11223344, 1'b1, 1'b1, 1'b0);
      x = i[1] ? 32'h44332211 : 32'h11223344;
      chk(got.data, x);
      chk(32'(got.parity), 32'(i[0] ? ^x : ~^x));
    end
    @(posedge pclk);
    bus_width <= RXSI_W16;
    send(32'h00001122, 1'b1, 1'b1, 1'b0);
    chk(got.data, 32'h00002211);
    @(posedge pclk);
    bus_width <= RXSI_W32;
    apb(1'b1, A_C1, 32'h0);
    send(32'h0, 1'b1, 1'b0, 1'b1);
    chk(32'(got.valid), 32'h0);
    apb(1'b1, A_C1, 32'h1);
    send(32'h0, 1'b1, 1'b0, 1'b1);
    chk({got.data[30:0], got.valid}, 32'h1);
    chk(32'(got.parity), 32'h1);
    send(32'h5, 1'b0, 1'b1, 1'b0);
  endtask : t_data
  task automatic t_gap;
    rxsi_mode_e m[4] = '{RXSI_SPI3, RXSI_SPI3, RXSI_UTOPIA2, RXSI_PKT2};
    for (int i = 0; i < 4; i++) begin
      bus_mode <= m[i];
      apb(1'b1, A_C1, (i == 1) ? 32'h0 : 32'h0300);
      send(32'h1, 1'b1, 1'b1, 1'b0);
      send(32'h2, 1'b1, 1'b1, 1'b0);
      repeat (20) @(posedge pclk);
      chk(32'(i == 0 ? last_gap >= 8'h03 : last_gap == 8'h00), 32'h1);
    end
    apb(1'b1, A_C1, 32'h0);
  endtask : t_gap
  task automatic t_loop;
    rxsi_width_e w[4] = '{RXSI_W32, RXSI_W32, RXSI_W8, RXSI_W16};
    logic [7:0] l[4] = '{8'h00, 8'h01, 8'h00, 8'h03};
    logic [7:0] g[4] = '{8'h01, 8'h01, 8'h00, 8'h02};
    bus_mode <= RXSI_SPI3;
    loopback_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus_width <= w[i];
      apb(1'b1, A_C2, {24'h0, l[i]});
      send(32'h3, 1'b1, 1'b0, 1'b0);
      send(32'h4, 1'b0, 1'b0, 1'b0);
      repeat (20) @(posedge pclk);
      chk(32'(last_gap), 32'(g[i]));
    end
    loopback_en <= 1'b0;
  endtask : t_loop
  task automatic t_burst;
    rxsi_width_e w[3] = '{RXSI_W32, RXSI_W32, RXSI_W16};
    logic [5:0] f[3] = '{6'h02, 6'h01, 6'h01};
    int x[3] = '{3, 3, 4};
    int k, n;
    other_port_ready <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus_width <= w[i];
      apb(1'b1, A_C2, {18'h0, f[i], 8'h0});
      k = 0;
      n = 0;
      src_word <= '{data: 32'h6, sop: 1'b0, eop: 1'b0, hec: 1'b0, more: 1'b1};
      src_valid <= 1'b1;
      @(negedge pclk);
      while (port_switch !== 1'b1 && n < 400) begin
        k += (src_take === 1'b1) ? 1 : 0;
        n++;
        @(negedge pclk);
      end
      chk(32'(k), 32'(x[i]));
      @(posedge pclk);
      src_valid <= 1'b0;
    end
    other_port_ready <= 1'b0;
  endtask : t_burst
  task automatic t_cell;
    @(posedge pclk);
    cell_avail <= 1'b0;
    bus_mode <= RXSI_UTOPIA3;
    apb(1'b1, A_C1, 32'h0);
    repeat (12) @(posedge pclk);
    cell_avail <= 1'b1;
    repeat (12) @(posedge pclk);
    chk(32'(rx_direct_avail_flag), 32'h1);
    send(32'h7, 1'b1, 1'b0, 1'b0);
    chk(32'(rx_direct_avail_flag), 32'h0);
    @(posedge pclk);
    cell_avail <= 1'b0;
    bus_mode <= RXSI_UTOPIA2;
    repeat (12) @(posedge pclk);
    cell_avail <= 1'b1;
    repeat (12) @(posedge pclk);
    send(32'h8, 1'b0, 1'b1, 1'b0);
    chk(32'(rx_direct_avail_flag), 32'h1);
    repeat (12) @(posedge pclk);
    chk(32'(rx_direct_avail_flag), 32'h0);
    cell_avail <= 1'b0;
    apb(1'b1, A_C1, 32'h20);
    repeat (12) @(posedge pclk);
    cell_avail <= 1'b1;
    src_empty <= 1'b1;
    repeat (12) @(posedge pclk);
    send(32'h9, 1'b0, 1'b0, 1'b0);
    chk(32'(rx_direct_avail_flag), 32'h1);
    send(32'ha, 1'b0, 1'b0, 1'b0);
    chk(32'(rx_direct_avail_flag), 32'h0);
    @(posedge pclk);
    src_empty <= 1'b0;
    cell_avail <= 1'b0;
    apb(1'b1, A_C1, 32'h0);
  endtask : t_cell
  initial begin
    {psel, penable, pwrite, paddr, pwdata, loopback_en, run} = '0;
    {src_word, src_valid, src_empty, cell_avail, poll_avail, other_port_ready} = '0;
    bus_mode = RXSI_SPI3;
    bus_width = RXSI_W32;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clk();
    t_flags();
    t_data();
    t_gap();
    t_loop();
    t_burst();
    t_cell();
    conclude();
  end
endmodule : rxsi_top_tb
`default_nettype wire
